// file: stp_pkg.sv
// package: register map, field layout and mode codes of the standard timer pulse/capture block
package stp_pkg;

    localparam int CNT_W  = 16;
    localparam int CMPP_W = 8;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL  = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_CMPA  = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_CMPP  = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 5'h0C;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 5'h10;

    // control register layout
    localparam int CTRL_W       = 9;
    localparam int CTRL_RUN     = 0;
    localparam int CTRL_MODE_LO = 1;
    localparam int CTRL_PIN_LO  = 3;
    localparam int CTRL_INIT    = 5;
    localparam int CTRL_INV     = 6;
    localparam int CTRL_SWAP    = 7;
    localparam int CTRL_CLRSRC  = 8;

    // flag register layout
    localparam int FLAG_A = 0;
    localparam int FLAG_P = 1;

    // reset values
    localparam logic [CTRL_W-1:0] RST_CTRL = 9'h000;
    localparam logic [CNT_W-1:0]  RST_CMPA = 16'h0000;
    localparam logic [CMPP_W-1:0] RST_CMPP = 8'h00;

    typedef enum logic [1:0] {
        STP_MODE_COMPARE = 2'b00,
        STP_MODE_CAPTURE = 2'b01,
        STP_MODE_PWM     = 2'b10,
        STP_MODE_TIMER   = 2'b11
    } stp_mode_e;

    // pin function codes
    localparam logic [1:0] PIN_FORCE_INACT = 2'b00;
    localparam logic [1:0] PIN_FORCE_ACT   = 2'b01;
    localparam logic [1:0] PIN_PWM         = 2'b10;
    localparam logic [1:0] PIN_PULSE       = 2'b11;

    // capture edge codes share the pin function field
    localparam logic [1:0] EDGE_RISE = 2'b00;
    localparam logic [1:0] EDGE_FALL = 2'b01;
    localparam logic [1:0] EDGE_BOTH = 2'b10;

endpackage

// file: stp_pin_sync.sv
// module: three-stage pin synchroniser with agreed-level edge pulses
`timescale 1ns/1ps
module stp_pin_sync (
    // clock and reset
    input  wire logic clock_i,
    input  wire logic resetn_i,
    // pin
    input  wire logic pin_i,
    // synchronised view
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);

    logic stage1;
    logic stage2;
    logic stage3;
    logic next_level;
    logic next_rise;
    logic next_fall;

    // change counts only when the last two stages agree
    always_comb begin
        next_level = level_o;
        if (stage2 == stage3) begin
            next_level = stage3;
        end
        next_rise = next_level & ~level_o;
        next_fall = ~next_level & level_o;
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stage1  <= 1'b0;
            stage2  <= 1'b0;
            stage3  <= 1'b0;
            level_o <= 1'b0;
            rise_o  <= 1'b0;
            fall_o  <= 1'b0;
        end else begin
            stage1  <= pin_i;
            stage2  <= stage1;
            stage3  <= stage2;
            level_o <= next_level;
            rise_o  <= next_rise;
            fall_o  <= next_fall;
        end
    end

endmodule

// file: stp_compare.sv
// module: comparators A and P and the PWM duty decision
`timescale 1ns/1ps
module stp_compare
    import stp_pkg::*;
(
    // timer state
    input  wire logic [CNT_W-1:0]  count_i,
    input  wire logic [CNT_W-1:0]  cmpa_i,
    input  wire logic [CMPP_W-1:0] cmpp_i,
    input  wire logic              swap_i,
    // results
    output logic                   a_match_o,
    output logic                   p_match_o,
    output logic                   pwm_active_o
);

    logic [CNT_W-1:0] count_inc;
    logic [CNT_W:0]   p_span;
    logic [CNT_W:0]   count_wide;
    logic [CNT_W:0]   cmpa_wide;

    always_comb begin
        count_inc  = count_i + 16'h0001;
        count_wide = {1'b0, count_i};
        cmpa_wide  = {1'b0, cmpa_i};
        // zero means a full 65536-clock span
        p_span = (cmpp_i == 8'h00) ? 17'h10000 : {1'b0, cmpp_i, 8'h00};
        // matches fire on the last count before the value, so a clear there gives exact spans
        a_match_o = (count_inc == cmpa_i);
        p_match_o = (count_inc == {cmpp_i, 8'h00});
        if (!swap_i) begin
            pwm_active_o = (count_wide < cmpa_wide) || (cmpa_wide >= p_span);
        end else begin
            pwm_active_o = (count_wide < p_span);
        end
    end

endmodule

// file: stp_timer.sv
// module: 16-bit standard timer with PWM, single pulse and capture modes on an Avalon-MM slave
`timescale 1ns/1ps
module stp_timer
    import stp_pkg::*;
(
    // clock and reset
    input  wire logic              clock_i,
    input  wire logic              resetn_i,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] address_i,
    input  wire logic              read_i,
    input  wire logic              write_i,
    input  wire logic [DATA_W-1:0] writedata_i,
    input  wire logic [3:0]        byteenable_i,
    output logic [DATA_W-1:0]      readdata_o,
    output logic                   waitrequest_o,
    // pins
    input  wire logic              ext_trigger_pin_i,
    input  wire logic              capture_pin_0_i,
    input  wire logic              capture_pin_1_i,
    output logic                   timer_out_o,
    // flag outputs
    output logic                   compare_a_flag_o,
    output logic                   compare_p_flag_o
);

    function automatic logic [DATA_W-1:0] merge_bytes(input logic [DATA_W-1:0] old_v,
                                                      input logic [DATA_W-1:0] new_v,
                                                      input logic [3:0]        be);
        logic [DATA_W-1:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
        logic hit;
        case (sel)
            EDGE_RISE: hit = rise;
            EDGE_FALL: hit = fall;
            EDGE_BOTH: hit = rise | fall;
            default:   hit = 1'b0;
        endcase
        return hit;
    endfunction

    // register state
    logic [CTRL_W-1:0] ctrl;
    logic [CNT_W-1:0]  compare_a_value;
    logic [CMPP_W-1:0] compare_p_value;
    logic [CNT_W-1:0]  count;
    logic              run_prev;

    logic [CTRL_W-1:0] next_ctrl;
    logic [CNT_W-1:0]  next_compare_a_value;
    logic [CMPP_W-1:0] next_compare_p_value;
    logic [CNT_W-1:0]  next_count;
    logic              next_timer_out;
    logic              next_a_flag;
    logic              next_p_flag;
    logic [DATA_W-1:0] next_readdata;
    logic              next_waitrequest;

    // control fields
    logic              counter_run;
    stp_mode_e         operating_mode_sel;
    logic [1:0]        pin_function_sel;
    logic              output_initial_level;
    logic              output_invert;
    logic              duty_period_swap;
    logic              clear_source_sel;

    assign counter_run          = ctrl[CTRL_RUN];
    assign operating_mode_sel   = stp_mode_e'(ctrl[CTRL_MODE_LO +: 2]);
    assign pin_function_sel     = ctrl[CTRL_PIN_LO +: 2];
    assign output_initial_level = ctrl[CTRL_INIT];
    assign output_invert        = ctrl[CTRL_INV];
    assign duty_period_swap     = ctrl[CTRL_SWAP];
    assign clear_source_sel     = ctrl[CTRL_CLRSRC];

    // synchronised pins
    logic trig_rise;
    logic cap0_rise;
    logic cap0_fall;
    logic cap1_rise;
    logic cap1_fall;

    stp_pin_sync u_trig_sync (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .pin_i    (ext_trigger_pin_i),
        .level_o  (),
        .rise_o   (trig_rise),
        .fall_o   ()
    );

    // capture pins are watched whatever the shared pin's direction
    stp_pin_sync u_cap0_sync (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .pin_i    (capture_pin_0_i),
        .level_o  (),
        .rise_o   (cap0_rise),
        .fall_o   (cap0_fall)
    );

    stp_pin_sync u_cap1_sync (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .pin_i    (capture_pin_1_i),
        .level_o  (),
        .rise_o   (cap1_rise),
        .fall_o   (cap1_fall)
    );

    // comparators
    logic a_match;
    logic p_match;
    logic pwm_active;

    stp_compare u_compare (
        .count_i      (count),
        .cmpa_i       (compare_a_value),
        .cmpp_i       (compare_p_value),
        .swap_i       (duty_period_swap),
        .a_match_o    (a_match),
        .p_match_o    (p_match),
        .pwm_active_o (pwm_active)
    );

    // mode decode
    logic pulse_mode;
    logic pwm_mode;
    logic capture_mode;
    logic run_rise;
    logic bus_write;
    logic bus_req;
    logic capture_hit;

    always_comb begin
        pulse_mode   = (operating_mode_sel == STP_MODE_PWM) && (pin_function_sel == PIN_PULSE);
        pwm_mode     = (operating_mode_sel == STP_MODE_PWM) && !pulse_mode;
        capture_mode = (operating_mode_sel == STP_MODE_CAPTURE);
        run_rise     = counter_run & ~run_prev;
        bus_req      = read_i | write_i;
        // a write lands on the edge where waitrequest is sampled low
        bus_write    = write_i & ~waitrequest_o;
        capture_hit  = capture_mode && counter_run &&
                       (edge_hit(pin_function_sel, cap0_rise, cap0_fall) ||
                        edge_hit(pin_function_sel, cap1_rise, cap1_fall));
    end

    // bus handshake: one wait cycle, data registered on the same edge that drops waitrequest
    // the master holds its request through the answer cycle; waitrequest low keeps it from counting twice
    always_comb begin
        next_waitrequest = !(bus_req && waitrequest_o);
        next_readdata    = readdata_o;
        if (bus_req && waitrequest_o && read_i) begin
            case (address_i)
                OFS_CTRL:  next_readdata = {23'h000000, ctrl};
                OFS_CMPA:  next_readdata = {16'h0000, compare_a_value};
                OFS_CMPP:  next_readdata = {24'h000000, compare_p_value};
                OFS_FLAGS: next_readdata = {30'h00000000, compare_p_flag_o, compare_a_flag_o};
                OFS_COUNT: next_readdata = {16'h0000, count};
                default:   next_readdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            waitrequest_o <= 1'b1;
            readdata_o    <= 32'h00000000;
        end else begin
            waitrequest_o <= next_waitrequest;
            readdata_o    <= next_readdata;
        end
    end

    // timer core
    always_comb begin
        logic [DATA_W-1:0] merged;
        logic              count_clear;
        logic              drive_act;
        merged               = 32'h00000000;
        count_clear          = 1'b0;
        drive_act            = 1'b0;
        next_ctrl            = ctrl;
        next_compare_a_value = compare_a_value;
        next_compare_p_value = compare_p_value;
        next_count           = count;
        next_timer_out       = timer_out_o;
        next_a_flag          = compare_a_flag_o;
        next_p_flag          = compare_p_flag_o;

        // software writes first, hardware events override below
        if (bus_write) begin
            case (address_i)
                OFS_CTRL: begin
                    merged    = merge_bytes({23'h000000, ctrl}, writedata_i, byteenable_i);
                    next_ctrl = merged[CTRL_W-1:0];
                end
                OFS_CMPA: begin
                    merged               = merge_bytes({16'h0000, compare_a_value}, writedata_i, byteenable_i);
                    next_compare_a_value = merged[CNT_W-1:0];
                end
                OFS_CMPP: begin
                    merged               = merge_bytes({24'h000000, compare_p_value}, writedata_i, byteenable_i);
                    next_compare_p_value = merged[CMPP_W-1:0];
                end
                OFS_FLAGS: begin
                    if (byteenable_i[0] && writedata_i[FLAG_A]) begin
                        next_a_flag = 1'b0;
                    end
                    if (byteenable_i[0] && writedata_i[FLAG_P]) begin
                        next_p_flag = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // counter
        if (run_rise) begin
            next_count = 16'h0000;
        end else if (counter_run) begin
            case (operating_mode_sel)
                STP_MODE_CAPTURE: count_clear = p_match;
                STP_MODE_PWM: begin
                    if (pulse_mode) begin
                        count_clear = 1'b0;
                    end else if (pwm_mode) begin
                        count_clear = duty_period_swap ? a_match : p_match;
                    end
                end
                default: count_clear = clear_source_sel ? a_match : p_match;
            endcase
            next_count = count_clear ? 16'h0000 : count + 16'h0001;
        end

        // events; hardware set wins over a software clear in the same cycle
        if (counter_run && !run_rise) begin
            case (operating_mode_sel)
                STP_MODE_CAPTURE: begin
                    if (p_match) begin
                        next_p_flag = 1'b1;
                    end
                end
                STP_MODE_PWM: begin
                    if (a_match) begin
                        next_a_flag = 1'b1;
                    end
                    if (p_match && !pulse_mode) begin
                        next_p_flag = 1'b1;
                    end
                    if (a_match && pulse_mode) begin
                        next_ctrl[CTRL_RUN] = 1'b0;
                    end
                end
                default: begin
                    if (a_match) begin
                        next_a_flag = 1'b1;
                    end
                    if (p_match && !clear_source_sel) begin
                        next_p_flag = 1'b1;
                    end
                end
            endcase
        end

        if (capture_hit) begin
            next_compare_a_value = count;
            next_a_flag          = 1'b1;
        end

        // trigger keeps the run bit set even if the A match clears it in the same cycle; the count then runs on without a restart
        if (pulse_mode && trig_rise) begin
            next_ctrl[CTRL_RUN] = 1'b1;
        end

        // forced levels only mask the pin; counting and flags carry on underneath
        // output pin
        case (operating_mode_sel)
            STP_MODE_PWM: begin
                if (pulse_mode) begin
                    drive_act = counter_run;
                end else begin
                    case (pin_function_sel)
                        PIN_FORCE_INACT: drive_act = 1'b0;
                        PIN_FORCE_ACT:   drive_act = 1'b1;
                        default:         drive_act = counter_run & pwm_active;
                    endcase
                end
                next_timer_out = (drive_act ? output_initial_level : ~output_initial_level) ^ output_invert;
            end
            STP_MODE_COMPARE: begin
                if (run_rise) begin
                    next_timer_out = output_initial_level ^ output_invert;
                end else if (counter_run && a_match) begin
                    case (pin_function_sel)
                        2'b01:   next_timer_out = output_invert;
                        2'b10:   next_timer_out = ~output_invert;
                        2'b11:   next_timer_out = ~timer_out_o;
                        default: next_timer_out = timer_out_o;
                    endcase
                end
            end
            default: next_timer_out = 1'b0;
        endcase
    end

    // run_prev resets low like the run bit, so the release of reset is no false start
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl             <= RST_CTRL;
            compare_a_value  <= RST_CMPA;
            compare_p_value  <= RST_CMPP;
            count            <= 16'h0000;
            run_prev         <= 1'b0;
            timer_out_o      <= 1'b0;
            compare_a_flag_o <= 1'b0;
            compare_p_flag_o <= 1'b0;
        end else begin
            ctrl             <= next_ctrl;
            compare_a_value  <= next_compare_a_value;
            compare_p_value  <= next_compare_p_value;
            count            <= next_count;
            run_prev         <= counter_run;
            timer_out_o      <= next_timer_out;
            compare_a_flag_o <= next_a_flag;
            compare_p_flag_o <= next_p_flag;
        end
    end

endmodule

// file: stp_timer_assertions.sv
// checker: bus handshake, sticky flags and pin relations of the timer
`timescale 1ns/1ps
module stp_timer_assertions
    import stp_pkg::*;
(
    // clock and reset
    input  wire logic              clock_i,
    input  wire logic              resetn_i,
    // avalon-mm
    input  wire logic [ADDR_W-1:0] address_i,
    input  wire logic              read_i,
    input  wire logic              write_i,
    input  wire logic [DATA_W-1:0] writedata_i,
    input  wire logic [3:0]        byteenable_i,
    input  wire logic [DATA_W-1:0] readdata_o,
    input  wire logic              waitrequest_o,
    // pins and flags
    input  wire logic              ext_trigger_pin_i,
    input  wire logic              timer_out_o,
    input  wire logic              compare_a_flag_o,
    input  wire logic              compare_p_flag_o
);
    logic [CTRL_W-1:0] ctl;
    logic [CTRL_W-1:0] next_ctl;
    logic              acc;
    logic              clr_a;
    logic              clr_p;
    logic              pulse;
    logic              cap;
    logic              cap_off;
    logic              act;
    // shadow of software writes only; hardware run clears are not tracked
    assign acc     = write_i && !waitrequest_o;
    assign clr_a   = acc && address_i == OFS_FLAGS && byteenable_i[0] && writedata_i[FLAG_A];
    assign clr_p   = acc && address_i == OFS_FLAGS && byteenable_i[0] && writedata_i[FLAG_P];
    assign pulse   = ctl[CTRL_MODE_LO+:2] == STP_MODE_PWM && ctl[CTRL_PIN_LO+:2] == PIN_PULSE;
    assign cap     = ctl[CTRL_MODE_LO+:2] == STP_MODE_CAPTURE;
    assign cap_off = cap && ctl[CTRL_PIN_LO+:2] == 2'b11;
    assign act     = ctl[CTRL_INIT] ^ ctl[CTRL_INV];
    always_comb begin
        next_ctl = (acc && address_i == OFS_CTRL) ? writedata_i[CTRL_W-1:0] : ctl;
    end
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctl <= RST_CTRL;
        end else begin
            ctl <= next_ctl;
        end
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    a_wait_one: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
        else $error("request not answered in the next cycle");
    a_wait_pulse: assert property (!waitrequest_o |=> waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    a_unmapped_zero: assert property (read_i && !waitrequest_o && address_i >= 5'h14 |-> readdata_o == '0)
        else $error("unmapped read returned nonzero");
    a_rdata_stands: assert property (!$stable(readdata_o) |-> !waitrequest_o && read_i)
        else $error("read data changed outside a read answer");
    a_flag_a_sticky: assert property (compare_a_flag_o && !clr_a |=> compare_a_flag_o)
        else $error("a flag dropped without clear");
    a_flag_p_sticky: assert property (compare_p_flag_o && !clr_p |=> compare_p_flag_o)
        else $error("p flag dropped without clear");
    a_cap_no_out: assert property (cap [*2] |-> !timer_out_o)
        else $error("output driven in capture mode");
    a_cap_off: assert property (cap_off [*2] |-> !$rose(compare_a_flag_o))
        else $error("capture with edge select disabled");
    a_pulse_trail: assert property (pulse && $rose(compare_a_flag_o) |=> timer_out_o != act)
        else $error("pulse not ended after a match");
    a_trig_start: assert property (pulse && $rose(ext_trigger_pin_i) && timer_out_o != act
        |-> ##[2:12] timer_out_o == act)
        else $error("trigger did not start a pulse");
endmodule

bind stp_timer stp_timer_assertions u_chk (
    .clock_i(clock_i), .resetn_i(resetn_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .ext_trigger_pin_i(ext_trigger_pin_i),
    .timer_out_o(timer_out_o), .compare_a_flag_o(compare_a_flag_o), .compare_p_flag_o(compare_p_flag_o)
);

// file: stp_pin_model.sv
// partner: trigger and capture pin driver, output pin observer
`timescale 1ns/1ps
module stp_pin_model (
    // clock
    input  wire logic clock_i,
    // observed output
    input  wire logic timer_out_i,
    // driven pins
    output logic      trig_o,
    output logic      cap0_o,
    output logic      cap1_o
);
    initial begin
        trig_o = 1'b0;
        cap0_o = 1'b0;
        cap1_o = 1'b0;
    end
    // held six clocks so the three-flop synchroniser always sees it
    task set_pin(input int k, input logic v);
        @(posedge clock_i);
        case (k)
            0: trig_o <= v;
            1: cap0_o <= v;
            default: cap1_o <= v;
        endcase
        repeat (6) @(posedge clock_i);
    endtask
    task high_time(input int n, output logic [31:0] hi);
        hi = '0;
        repeat (n) begin
            @(posedge clock_i);
            if (timer_out_i === 1'b1) begin
                hi = hi + 1;
            end
        end
    endtask
endmodule

// file: test_stp_timer.sv
// testbench: register, single pulse, capture and pwm sequences
`timescale 1ns/1ps
module test_stp_timer;
    import stp_pkg::*;
    logic              clock_i = 1'b0;
    logic              resetn_i = 1'b0;
    logic [ADDR_W-1:0] address_i = '0;
    logic              read_i = 1'b0;
    logic              write_i = 1'b0;
    logic [DATA_W-1:0] writedata_i = '0;
    logic [3:0]        byteenable_i = 4'hF;
    logic [DATA_W-1:0] readdata_o;
    logic              waitrequest_o;
    logic              trig;
    logic              cap0;
    logic              cap1;
    logic              timer_out_o;
    logic              fa;
    logic              fp;
    logic [DATA_W-1:0] q;
    logic [DATA_W-1:0] c;
    logic [DATA_W-1:0] hi;
    int                failures = 0;
    int                checks = 0;
    int                cyc = 0;
    logic [ADDR_W-1:0] offs [7] = '{OFS_CTRL, OFS_CMPA, OFS_CMPP, OFS_FLAGS, OFS_COUNT, 5'h14, 5'h1C};
    int sw [5] = '{1, 0, 0, 0, 0};
    int ca [5] = '{1000, 64, 300, 64, 64};
    int pn [5] = '{2, 2, 2, 0, 1};
    int nn [5] = '{1000, 512, 256, 256, 256};
    int ex [5] = '{256, 384, 256, 0, 256};

    always #2 clock_i = ~clock_i;

    stp_timer u_dut (
        .clock_i(clock_i), .resetn_i(resetn_i), .address_i(address_i), .read_i(read_i),
        .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
        .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .ext_trigger_pin_i(trig),
        .capture_pin_0_i(cap0), .capture_pin_1_i(cap1), .timer_out_o(timer_out_o),
        .compare_a_flag_o(fa), .compare_p_flag_o(fp)
    );
    stp_pin_model u_pins (
        .clock_i(clock_i), .timer_out_i(timer_out_o), .trig_o(trig), .cap0_o(cap0), .cap1_o(cap1)
    );

    task bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clock_i);
        read_i <= ~wr;
        write_i <= wr;
        address_i <= a;
        writedata_i <= d;
        do @(posedge clock_i); while (waitrequest_o !== 1'b0);
        q = readdata_o;
        read_i <= 1'b0;
        write_i <= 1'b0;
    endtask
    task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        bus(1'b1, a, d);
    endtask
    task rd(input logic [ADDR_W-1:0] a);
        bus(1'b0, a, '0);
    endtask
    task chk(input string n, input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] e);
        checks++;
        if (s !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    function automatic logic [DATA_W-1:0] cw(input logic r, input logic [1:0] m, input logic [1:0] p,
                                             input logic inv, input logic swp, input logic clr);
        return {23'h0, clr, swp, inv, 1'b1, p, m, r};
    endfunction
    task test_done();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ceiling well above the roughly 9.4k cycles the sequence needs
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            test_done();
        end
    end

    initial begin
        repeat (12) @(posedge clock_i);
        resetn_i <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(offs[i]);
            chk("reset value", q, '0);
        end
        wr(OFS_COUNT, 32'h0000_1234);
        rd(OFS_COUNT);
        chk("count read only", q, '0);
        wr(5'h14, 32'hFFFF_FFFF);
        rd(5'h14);
        chk("unmapped", q, '0);
        $display("test registers done");

        // compare p and swap set to prove they are ignored
        wr(OFS_CMPA, 32'd300);
        wr(OFS_CMPP, 32'd1);
        wr(OFS_CTRL, cw(1, STP_MODE_PWM, PIN_PULSE, 0, 1, 1));
        repeat (3) @(posedge clock_i);
        chk("pulse lead", timer_out_o, 1);
        for (int i = 0; i < 500 && fa !== 1'b1; i++) @(posedge clock_i);
        chk("pulse a flag", fa, 1);
        repeat (2) @(posedge clock_i);
        chk("pulse trail", timer_out_o, 0);
        rd(OFS_CTRL);
        chk("run cleared", q[CTRL_RUN], 0);
        rd(OFS_COUNT);
        c = q;
        rd(OFS_COUNT);
        chk("count held", q, c);
        wr(OFS_FLAGS, 32'h3);
        @(posedge clock_i);
        chk("a flag cleared", fa, 0);
        fork
            u_pins.set_pin(0, 1);
            u_pins.high_time(400, hi);
        join
        chk("pulse width", hi >= 298 && hi <= 302, 1);
        chk("a flag again", fa, 1);
        chk("pulse no p flag", fp, 0);
        u_pins.set_pin(0, 0);
        $display("test single pulse done");

        wr(OFS_CTRL, cw(0, STP_MODE_CAPTURE, EDGE_RISE, 1, 1, 1));
        rd(OFS_COUNT);
        c = q;
        rd(OFS_COUNT);
        chk("capture idle", q, c);
        for (int e = 0; e < 4; e++) begin
            wr(OFS_CTRL, cw(1, STP_MODE_CAPTURE, 2'(e), 1, 1, 1));
            wr(OFS_FLAGS, 32'h3);
            u_pins.set_pin(e % 2 + 1, 1);
            rd(OFS_FLAGS);
            chk("capture rise", q[FLAG_A], e == 0 || e == 2);
            wr(OFS_FLAGS, 32'h1);
            u_pins.set_pin(e % 2 + 1, 0);
            rd(OFS_FLAGS);
            chk("capture fall", q[FLAG_A], e == 1 || e == 2);
        end
        rd(OFS_CMPA);
        chk("captured below p", q < 256, 1);
        chk("capture no output", timer_out_o, 0);
        wr(OFS_FLAGS, 32'h3);
        repeat (300) @(posedge clock_i);
        rd(OFS_FLAGS);
        chk("capture p flag", q[FLAG_P], 1);
        chk("capture p flag pin", fp, 1);
        wr(OFS_CMPP, 32'd0);
        repeat (300) @(posedge clock_i);
        rd(OFS_COUNT);
        chk("capture full count", q >= 256, 1);
        $display("test capture done");

        for (int i = 0; i < 5; i++) begin
            wr(OFS_CMPA, ca[i]);
            wr(OFS_CMPP, 32'd1);
            // second pass runs inverted so the polarity bit is exercised
            wr(OFS_CTRL, cw(0, STP_MODE_PWM, 2'(pn[i]), i == 1, sw[i], 1));
            wr(OFS_CTRL, cw(1, STP_MODE_PWM, 2'(pn[i]), i == 1, sw[i], 1));
            wr(OFS_FLAGS, 32'h3);
            repeat (1100) @(posedge clock_i);
            u_pins.high_time(nn[i], hi);
            chk("pwm high time", hi, ex[i]);
            rd(OFS_FLAGS);
            chk("pwm period flag", q[sw[i] ? FLAG_A : FLAG_P], 1);
        end
        $display("test pwm done");
        test_done();
    end
endmodule
